// ---- hdl/ibic_pkg.sv ----
// constants for the bus interface channel
package ibic_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] ADDR_MSTCR = 32'hffff861c;
    localparam logic [31:0] ADDR_XCTL = 32'hffff87f0;
    localparam logic [31:0] ADDR_CTL = 32'hffff8808;
    localparam logic [31:0] ADDR_STS = 32'hffff8809;
    localparam logic [31:0] ADDR_DATA = 32'hffff880e;
    localparam logic [31:0] ADDR_SAR = 32'hffff880f;
    // standby register
    localparam int STBY_BIT = 5;
    localparam logic [15:0] STBY_RST = 16'hffff;
    // control register fields
    localparam int CTL_ICE = 7;
    localparam int CTL_IRQ_ENABLE = 6;
    localparam int CTL_MST = 5;
    localparam int CTL_TRS = 4;
    localparam int CTL_ACK_CHECK_ENABLE = 3;
    localparam int CTL_BUS_BUSY = 2;
    localparam int CTL_IRQ_FLAG = 1;
    localparam int CTL_SCP = 0;
    localparam logic [7:0] CTL_RST = 8'h01;
    // mode register fields
    localparam int MODE_MLS = 7;
    localparam int MODE_WAIT = 6;
    localparam int MODE_CKS_LO = 3;
    localparam logic [7:0] MODE_RST = 8'h00;
    // extended control fields
    localparam int X_RATE = 5;
    localparam int X_ACC = 4;
    localparam int X_HANDSHAKE_RECEIVE = 3;
    localparam int X_RXV = 1;
    localparam int X_STOP_IRQ_MASK = 0;
    localparam logic [7:0] X_WMASK = 8'h39;
    localparam logic [7:0] X_RST = 8'h00;
    // status fields
    localparam int STS_ERROR_STOP_FLAG = 7;
    localparam int STS_STOP = 6;
    localparam int STS_AL = 3;
    localparam int STS_RECEIVED_ACK = 0;
    // clock: 40 MHz / 156 kHz is 256 cycles per bit at rate bit set and clock select 7
    localparam int SYS_MHZ = 100;
    localparam int REF_MHZ = 40;
    localparam int REF_DIV_MAX = 256;
    localparam int DIV_W = 12;
    localparam int BITS_FRAME = 9;
    localparam logic [3:0] BITS_FRAME_L = 4'd9;
    typedef enum logic [2:0] {
        IBIC_IDLE, IBIC_START, IBIC_BIT, IBIC_HOLD, IBIC_STOP
    } ibic_state_t;
endpackage

// ---- hdl/ibic_channel.sv ----
// single bus interface channel, master transmit and receive
`timescale 1ns/1ps
module ibic_channel
    import ibic_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [ibic_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_irq,
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe
);
    import ibic_pkg::*;

    logic [15:0] stby_q;
    logic [7:0] xctl_q, ctl_q, mode_q, sts_q, data_q, sar_q, sarx_q;
    logic [15:0] rdata_q;
    logic [1:0] scl_s_q, sda_s_q;
    logic sda_prev_q, scl_prev_q;
    ibic_state_t st_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic sda_drv_q, scl_drv_q;
    logic stop_pend_q;

    wire run = ~stby_q[STBY_BIT];
    wire acc = run & xctl_q[X_ACC];
    wire interface_enable = ctl_q[CTL_ICE];
    wire sel_mst = i_addr == ADDR_MSTCR;
    wire sel_x = run & (i_addr == ADDR_XCTL);
    wire sel_ctl = acc & (i_addr == ADDR_CTL);
    wire sel_sts = acc & (i_addr == ADDR_STS);
    // shared offsets: enable selects data/mode, else address regs
    wire sel_data = acc & interface_enable & (i_addr == ADDR_DATA);
    wire sel_sarx = acc & ~interface_enable & (i_addr == ADDR_DATA);
    wire sel_mode = acc & interface_enable & (i_addr == ADDR_SAR);
    wire sel_sar = acc & ~interface_enable & (i_addr == ADDR_SAR);
    wire sda_in = sda_s_q[1];
    wire scl_in = scl_s_q[1];
    // bit period from clock select and rate bit
    wire [2:0] cks = mode_q[MODE_CKS_LO+2:MODE_CKS_LO];
    wire [8:0] ref_div = xctl_q[X_RATE] ?
        9'(REF_DIV_MAX - 32 * (7 - int'(cks))) :
        9'(REF_DIV_MAX / 2 - 16 * (7 - int'(cks)));
    wire [DIV_W-1:0] quarter = DIV_W'((int'(ref_div) * SYS_MHZ)
        / (REF_MHZ * 4));
    // one quarter bit is quarter cycles, counted from zero
    wire tick = (div_q == quarter - DIV_W'(1)) & (st_q != IBIC_IDLE);
    wire master = ctl_q[CTL_MST];
    wire tx = ctl_q[CTL_TRS];
    wire out_bit = mode_q[MODE_MLS] ? sh_q[0] : sh_q[7];
    wire ack_slot = bit_q == BITS_FRAME_L - 4'd1;
    wire frame_end = tick & (st_q == IBIC_BIT) & (ph_q == 2'd3)
        & ack_slot;
    wire start_done = tick & (st_q == IBIC_START) & (ph_q == 2'd3);
    wire stop_done = tick & (st_q == IBIC_STOP) & (ph_q == 2'd3);
    // ack read mid clock high, before the receiver lets go
    wire ack_sample = tick & (st_q == IBIC_BIT) & (ph_q == 2'd1)
        & ack_slot;
    // released data bit seen low: another master won
    wire lost = tick & (st_q == IBIC_BIT) & (ph_q == 2'd1) & ~ack_slot
        & tx & master & ~sda_drv_q & ~sda_in;

    // bus-side stop and start detect for slave status
    wire bus_stop = scl_in & scl_prev_q & sda_in & ~sda_prev_q;
    wire bus_start = scl_in & scl_prev_q & ~sda_in & sda_prev_q;

    // only the format with both format bits zero is built
    wire fmt_i2c = ~sar_q[0] & ~sarx_q[0];
    wire ctl_wr = i_wr & sel_ctl;
    wire req_start = ctl_wr & ~i_wdata[CTL_SCP] & i_wdata[CTL_BUS_BUSY]
        & interface_enable & master & fmt_i2c & (st_q == IBIC_IDLE);
    wire req_stop = ctl_wr & ~i_wdata[CTL_SCP] & ~i_wdata[CTL_BUS_BUSY]
        & interface_enable & master & ctl_q[CTL_BUS_BUSY];
    // nack with ack check refuses the next byte
    wire nack_hold = ctl_q[CTL_ACK_CHECK_ENABLE] & sts_q[STS_RECEIVED_ACK] & tx;
    // launch next byte when flag cleared
    wire launch = ctl_wr & ~i_wdata[CTL_IRQ_FLAG] & ctl_q[CTL_IRQ_FLAG]
        & ~nack_hold & (st_q == IBIC_HOLD);
    wire data_wr = i_wr & sel_data;
    wire slave_stop_irq = bus_stop & ~master & ~xctl_q[X_STOP_IRQ_MASK];
    wire irq_set = start_done | frame_end | slave_stop_irq | lost;
    wire rx_byte_done = frame_end & ~tx;
    // without handshake, reception runs on frame to frame
    wire rx_more = ~tx & ~xctl_q[X_HANDSHAKE_RECEIVE] & ~stop_pend_q & ~req_stop;


    // input synchronisers
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_s_q <= {scl_s_q[0], i_scl};
            sda_s_q <= {sda_s_q[0], i_sda};
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
        end
    end

    // software registers
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            stby_q <= STBY_RST;
            xctl_q <= X_RST;
            mode_q <= MODE_RST;
            sar_q <= 8'h00;
            sarx_q <= 8'h00;
        end
        else
        begin
            if (i_wr & sel_mst)
                stby_q <= {8'h00, i_wdata};
            if (i_wr & sel_x)
                xctl_q <= (i_wdata & X_WMASK) | (xctl_q & ~X_WMASK);
            if (i_wr & sel_mode)
                mode_q <= i_wdata;
            if (i_wr & sel_sar)
                sar_q <= i_wdata;
            if (i_wr & sel_sarx)
                sarx_q <= i_wdata;
            // receive valid set wins over read clear
            if (rx_byte_done)
                xctl_q[X_RXV] <= 1'b1;
            else if (i_rd & sel_data)
                xctl_q[X_RXV] <= 1'b0;
        end
    end

    // control register with flag and busy
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            ctl_q <= CTL_RST;
        else
        begin
            if (ctl_wr)
                ctl_q <= {i_wdata[7:3], ctl_q[CTL_BUS_BUSY],
                    ctl_q[CTL_IRQ_FLAG] & i_wdata[CTL_IRQ_FLAG], i_wdata[CTL_SCP]};
            if (start_done | bus_start)
                ctl_q[CTL_BUS_BUSY] <= 1'b1;
            else if (stop_done | bus_stop)
                ctl_q[CTL_BUS_BUSY] <= 1'b0;
            if (irq_set)
                ctl_q[CTL_IRQ_FLAG] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            sts_q <= 8'h00;
        else
        begin
            if (i_wr & sel_sts)
                sts_q[7:1] <= sts_q[7:1] & i_wdata[7:1];
            if (bus_stop)
                sts_q[STS_STOP] <= 1'b1;
            if (bus_stop & (st_q == IBIC_BIT))
                sts_q[STS_ERROR_STOP_FLAG] <= 1'b1;
            if (lost)
                sts_q[STS_AL] <= 1'b1;
            if (ack_sample)
                sts_q[STS_RECEIVED_ACK] <= tx ? sda_in : 1'b0;
        end
    end

    // master bus sequencer
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= IBIC_IDLE;
            div_q <= '0;
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            data_q <= 8'h00;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end
        else
        begin
            div_q <= tick ? '0 : ((st_q == IBIC_IDLE) ? '0 : div_q + 1'b1);
            if (tick)
                ph_q <= ph_q + 2'd1;
            if (data_wr)
                data_q <= i_wdata;
            if (req_stop)
                stop_pend_q <= 1'b1;
            case (st_q)
                IBIC_IDLE:
                begin
                    stop_pend_q <= 1'b0;
                    if (req_start)
                    begin
                        st_q <= IBIC_START;
                        ph_q <= 2'd0;
                    end
                end
                IBIC_START:
                begin
                    if (tick & (ph_q == 2'd1))
                        sda_drv_q <= 1'b1;
                    if (start_done)
                    begin
                        scl_drv_q <= 1'b1;
                        st_q <= IBIC_HOLD;
                    end
                end
                IBIC_HOLD:
                begin
                    if (stop_pend_q | req_stop)
                    begin
                        st_q <= IBIC_STOP;
                        ph_q <= 2'd0;
                        sda_drv_q <= 1'b1;
                    end
                    else if (launch)
                    begin
                        st_q <= IBIC_BIT;
                        ph_q <= 2'd0;
                        bit_q <= 4'd0;
                        sh_q <= tx ? data_q : 8'h00;
                        sda_drv_q <= tx & ~(mode_q[MODE_MLS] ?
                            data_q[0] : data_q[7]);
                    end
                end
                IBIC_BIT:
                begin
                    if (tick & (ph_q == 2'd0))
                        scl_drv_q <= 1'b0;
                    if (tick & (ph_q == 2'd1) & ~ack_slot)
                        sh_q <= mode_q[MODE_MLS] ?
                            {sda_in, sh_q[7:1]} : {sh_q[6:0], sda_in};
                    // step off the bus after losing
                    if (lost)
                    begin
                        st_q <= IBIC_IDLE;
                        scl_drv_q <= 1'b0;
                    end
                    if (tick & (ph_q == 2'd2))
                        scl_drv_q <= 1'b1;
                    if (tick & (ph_q == 2'd3))
                    begin
                        bit_q <= bit_q + 4'd1;
                        if (ack_slot)
                        begin
                            st_q <= rx_more ? IBIC_BIT : IBIC_HOLD;
                            // next frame counts from zero again
                            bit_q <= 4'd0;
                            sda_drv_q <= 1'b0;
                            if (~tx)
                                data_q <= sh_q;
                        end
                        else if (bit_q == BITS_FRAME_L - 4'd2)
                            // receiver acks low, transmitter releases
                            sda_drv_q <= ~tx;
                        else
                            sda_drv_q <= tx & ~(mode_q[MODE_MLS] ?
                                sh_q[0] : sh_q[7]);
                    end
                end
                IBIC_STOP:
                begin
                    if (tick & (ph_q == 2'd1))
                        scl_drv_q <= 1'b0;
                    if (stop_done)
                    begin
                        sda_drv_q <= 1'b0;
                        st_q <= IBIC_IDLE;
                    end
                end
                default:
                    st_q <= IBIC_IDLE;
            endcase
        end
    end

    wire [7:0] rd_x = xctl_q & 8'h3b;
    wire [15:0] rd_mux = sel_mst ? stby_q :
        sel_x ? {8'h00, rd_x} :
        sel_ctl ? {8'h00, ctl_q} :
        sel_sts ? {8'h00, sts_q} :
        sel_data ? {8'h00, data_q} :
        sel_mode ? {8'h00, mode_q} :
        sel_sar ? {8'h00, sar_q} :
        sel_sarx ? {8'h00, sarx_q} : 16'h0000;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_q <= 16'h0000;
        else
            rdata_q <= i_rd ? rd_mux : 16'h0000;
    end

    assign o_rdata = rdata_q;
    assign o_irq = ctl_q[CTL_IRQ_ENABLE] & ctl_q[CTL_IRQ_FLAG];
    // clock drives only in master mode; data drives whenever the sequencer does outside standby
    assign o_scl = 1'b0;
    assign o_scl_oe = scl_drv_q & master & run;
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_drv_q & run;
    wire unused = out_bit;
endmodule

// ---- verification/ibic_channel_properties.sv ----
// port assertions for the bus interface channel
`timescale 1ns/1ps
module ibic_channel_properties
    import ibic_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [ibic_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic o_irq,
    input wire logic i_scl,
    input wire logic o_scl,
    input wire logic o_scl_oe,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    wire ctl_wr = i_wr && i_addr == ADDR_CTL;
    wire mapped = i_addr inside {ADDR_MSTCR, ADDR_XCTL, ADDR_CTL, ADDR_STS,
        ADDR_DATA, ADDR_SAR};
    a_rdata_quiet: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not zero outside answer");
    a_unmapped_zero: assert property (
        i_rd && !mapped |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (
        i_rd && i_addr != ADDR_MSTCR |=> o_rdata[15:8] == 8'h00)
        else $error("byte register upper half not zero");
    a_irq_off: assert property (
        ctl_wr && !i_wdata[CTL_IRQ_ENABLE] |=> !o_irq)
        else $error("interrupt with enable cleared");
    a_irq_clear: assert property (
        ctl_wr && !i_wdata[CTL_IRQ_FLAG] |=> !o_irq [*8])
        else $error("flag not cleared by write");
    a_pins_low: assert property (!o_scl && !o_sda)
        else $error("open drain output driven high");
    a_start_hold: assert property (
        $rose(o_sda_oe) && !o_scl_oe |=> !o_scl_oe [*8])
        else $error("start condition not held");
    a_stop_idle: assert property (
        $fell(o_sda_oe) && !o_scl_oe |=> (!o_sda_oe && !o_scl_oe) [*8])
        else $error("bus not idle after stop");
endmodule
bind ibic_channel ibic_channel_properties u_props (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(i_scl),
    .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe));

// ---- verification/ibic_slave_model.sv ----
// serial slave model receiving and acknowledging bytes
`timescale 1ns/1ps
module ibic_slave_model (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_nack,
    output logic o_sda_oe,
    output logic [7:0] o_byte,
    output logic o_done,
    output logic o_stop,
    output realtime o_per
);
    int cnt = 0;
    realtime t_q = 0;
    logic [7:0] sh = 8'h00;
    initial
    begin
        o_sda_oe = 1'b0;
        o_byte = 8'h00;
        o_done = 1'b0;
        o_stop = 1'b0;
        o_per = 0;
    end
    always @(negedge i_sda)
    begin
        if (i_scl === 1'b1)
        begin
            cnt = 0;
            o_stop = 1'b0;
        end
    end
    always @(posedge i_sda)
    begin
        if (i_scl === 1'b1)
            o_stop = 1'b1;
    end
    always @(posedge i_scl)
    begin
        o_per = $realtime - t_q;
        t_q = $realtime;
        if (cnt < 8)
            sh = {sh[6:0], i_sda};
        cnt = cnt + 1;
    end
    always @(negedge i_scl)
    begin
        if (cnt == 8)
            o_sda_oe = !i_nack;
        else if (cnt == 9)
        begin
            o_sda_oe = 1'b0;
            o_byte = sh;
            o_done = !o_done;
            cnt = 0;
        end
    end
endmodule

// ---- verification/ibic_channel_tb_top.sv ----
// self-checking bench for the bus interface channel
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("ERROR %0t mismatch %h %h", $time, a, b); \
        end \
    end
module ibic_channel_tb_top;
    import ibic_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic o_irq, o_scl, o_scl_oe, o_sda, o_sda_oe;
    logic s_oe, s_done, s_stop;
    logic s_nack = 1'b0;
    logic [7:0] s_byte;
    realtime s_per;
    logic rd_q = 1'b0;
    logic [15:0] exp_q[$], msk_q[$];
    logic [7:0] byte_q[$];
    int failures = 0;
    int comparisons = 0;
    logic [7:0] lfsr = 8'h5b;
    wire scl = (o_scl_oe && !o_scl) ? 1'b0 : 1'b1;
    wire sda = ((o_sda_oe && !o_sda) || s_oe) ? 1'b0 : 1'b1;
    ibic_channel u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(scl), .o_scl(o_scl),
        .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe));
    ibic_slave_model u_slave (.i_scl(scl), .i_sda(sda), .i_nack(s_nack),
        .o_sda_oe(s_oe), .o_byte(s_byte), .o_done(s_done), .o_stop(s_stop),
        .o_per(s_per));
    initial
    begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic conclude();
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e,
        input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask
    task automatic wait_sig(input logic stop);
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk_sys);
            n++;
        end
        while ((stop ? s_stop : o_irq) !== 1'b1 && n < 20000);
        if (n >= 20000)
        begin
            failures++;
            $display("ERROR %0t wait timed out", $time);
            conclude();
        end
    endtask
    task automatic send(input logic [7:0] b, input logic nack);
        s_nack = nack;
        byte_q.push_back(b);
        wr(ADDR_DATA, b);
        wr(ADDR_CTL, 8'hfd);
        wait_sig(1'b0);
        `CHK(int'(s_per), 6400) // bit period
        rd(ADDR_STS, {15'h0000, nack}, 16'h0001); // ack stored
    endtask
    always @(posedge i_clk_sys)
    begin
        rd_q <= i_rd;
        if (rd_q)
            `CHK(o_rdata & msk_q.pop_front(), exp_q.pop_front()) // read
    end
    always @(s_done)
    begin
        if (i_nrst)
            `CHK(s_byte, byte_q.pop_front()) // byte on wire
    end
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        rd(ADDR_MSTCR, STBY_RST, 16'hffff); // standby at reset
        rd(ADDR_XCTL, 16'h0000, 16'hffff); // closed in standby
        wr(ADDR_MSTCR, 8'hdf);
        rd(ADDR_CTL, 16'h0000, 16'hffff); // closed before enable
        rd(32'hffff8800, 16'h0000, 16'hffff); // unmapped place
        wr(ADDR_XCTL, 8'hf9);
        rd(ADDR_XCTL, 16'h0039, 16'hffff); // reserved bits zero
        wr(ADDR_CTL, 8'h09);
        lfsr = nxt(lfsr);
        wr(ADDR_SAR, {lfsr[7:1], 1'b0});
        rd(ADDR_SAR, {8'h00, lfsr[7:1], 1'b0}, 16'hffff);
        wr(ADDR_CTL, 8'h89);
        wr(ADDR_SAR, 8'h38);
        rd(ADDR_SAR, 16'h0038, 16'hffff); // mode visible
        rd(ADDR_CTL, 16'h0089, 16'hffff); // bus free
        wr(ADDR_CTL, 8'hb9); // master transmit first
        wr(ADDR_CTL, 8'hfc);
        wait_sig(1'b0);
        send(8'ha0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            lfsr = nxt(lfsr);
            send(lfsr, 1'b0);
        end
        send(8'h5a, 1'b1);
        wr(ADDR_CTL, 8'hf9);
        repeat (7000) @(posedge i_clk_sys);
        rd(ADDR_CTL, 16'h0000, 16'h0002); // no byte after nack
        wr(ADDR_CTL, 8'hf0);
        wait_sig(1'b1);
        repeat (4) @(posedge i_clk_sys);
        rd(ADDR_CTL, 16'h0000, 16'h0004); // busy cleared
        repeat (2) @(posedge i_clk_sys);
        conclude();
    end
endmodule
